/* rtl/store_unit_pkg.sv */
// Constants, field layouts and carriers shared by the store address and data unit
package store_unit_pkg;

   // APB register byte offsets
   localparam logic [7:0] INSN_OFFSET     = 8'h00;
   localparam logic [7:0] COUNT_OFFSET    = 8'h04;
   localparam logic [7:0] GPR_SEL_OFFSET  = 8'h08;
   localparam logic [7:0] GPR_DATA_OFFSET = 8'h0c;
   localparam logic [7:0] STATUS_OFFSET   = 8'h10;
   localparam logic [7:0] LAST_EA_OFFSET  = 8'h14;

   // Instruction word field positions
   localparam int KIND_LSB    = 30;
   localparam int SIZE_LSB    = 28;
   localparam int INDEXED_BIT = 27;
   localparam int UPDATE_BIT  = 26;
   localparam int SOURCE_LSB  = 21;
   localparam int BASE_LSB    = 16;
   localparam int INDEX_LSB   = 11;
   localparam int SWAP_BIT    = 1;
   localparam int RECORD_BIT  = 0;

   // Operation kinds carried in the instruction word
   localparam logic [1:0] KIND_SINGLE     = 2'h0;
   localparam logic [1:0] KIND_MULTIPLE   = 2'h1;
   localparam logic [1:0] KIND_STRING_IMM = 2'h2;
   localparam logic [1:0] KIND_STRING_IDX = 2'h3;

   // Access sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Counts and register numbers
   localparam logic [6:0] STRING_MAX_BYTES = 7'h20;
   localparam logic [4:0] GPR_ZERO         = 5'h00;
   localparam logic [4:0] GPR_LAST         = 5'h1f;
   localparam logic [1:0] BYTE_LAST        = 2'h3;

   // Reset values
   localparam logic [31:0] INSN_RESET  = 32'h0000_0000;
   localparam logic [6:0]  COUNT_RESET = 7'h00;

   // One store beat towards the data storage path
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;   // Right aligned
      logic [2:0]  bytes;  // 1, 2 or 4
   } store_req_s;

   // Exceptions reported by the storage path for the beat on offer
   typedef struct packed {
      logic dataStorage;
      logic translationMiss;
      logic addrCompare;
   } store_exc_s;

endpackage

/* rtl/gpr_file.sv */
// General register file: 32 words, one registered read port, one write port
`timescale 1ns/1ps
`default_nettype none
module gpr_file (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstN,
   // Read port, data one cycle after the address
   input  wire logic [4:0]  rdAddr,
   output logic      [31:0] rdData,
   // Write port
   input  wire logic        wrEn,
   input  wire logic [4:0]  wrAddr,
   input  wire logic [31:0] wrData
);

   logic [31:0] mem [0:31];

   // Array has no reset; software loads it before use
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read data
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdData <= 32'h0000_0000;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

endmodule
`default_nettype wire

/* rtl/store_unit.sv */
// Store address and data unit with APB control and a storage request port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Indexed forms add the full index register to the base value.
// RULE2: Displacement forms sign-extend the 16-bit displacement and add it to base.
// RULE3: Base value is zero when the base field is register 0.
// RULE4: Byte stores write source bits 24:31, the low byte.
// RULE5: Halfword stores write the source's low sixteen bits.
// RULE6: Swapped halfword store exchanges the two low bytes before writing.
// RULE7: Swapped word store reverses all four bytes before writing.
// RULE8: Word stores write the whole source register.
// RULE9: Update forms write the address back; base zero is an invalid form.
// RULE10: Record bit set leaves condition field zero undefined; nothing produced.
// RULE11: Store multiple writes source through register 31 into consecutive words.
// RULE12: Interrupted multiple and string stores restart from the first register.
// RULE13: Immediate string store address is base value only, no displacement.
// RULE14: Immediate string count comes from the count field; zero means 32.
// RULE15: String stores walk successive registers, wrapping from 31 to 0.
// RULE16: String bytes leave each register most significant byte first.
// RULE17: Indexed string store takes its count from the string length field.
// RULE18: Zero string length makes the indexed string store a no-operation.
// RULE19: Zero-length indexed string store takes no storage exception interrupt.
module store_unit (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Storage path
   output logic                          storeValid,
   output store_unit_pkg::store_req_s    storeReq,
   input  wire logic                     storeReady,
   input  wire store_unit_pkg::store_exc_s storeExc,
   output logic                          excTaken,
   // Core interrupt request, abandons the operation in flight
   input  wire logic                     abortReq
);

   typedef enum logic [2:0] {IDLE, GET_BASE, GET_INDEX, CALC, GET_SRC, LOAD, SEND, WRBACK} state_e;

   typedef struct packed {
      state_e      st;
      logic [31:0] insn;
      logic [6:0]  count;    // String length field
      logic [4:0]  gprSel;
      logic [31:0] base;
      logic [31:0] ea;       // Start address of the operation
      logic [31:0] cur;      // Address of the beat on offer
      logic [31:0] word;
      logic [4:0]  srcReg;
      logic [6:0]  remain;
      logic [1:0]  byteIdx;
      logic        invalid;
      logic        excSeen;
   } state_s;

   state_s      r;
   state_s      n;
   logic [1:0]  rstSync;
   logic        rstN;
   logic [4:0]  rdAddr;
   logic [31:0] rdData;
   logic        wrEn;
   logic [4:0]  wrAddr;
   logic [31:0] wrData;
   logic        access;
   logic        busy;
   logic        anyExc;

   // Byte order exchange of a halfword
   function automatic logic [15:0] swapHalf(input logic [15:0] h);
      swapHalf = {h[7:0], h[15:8]};
   endfunction

   // Byte order reversal of a word
   function automatic logic [31:0] swapWord(input logic [31:0] w);
      swapWord = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   // Five-bit register field of the instruction word
   function automatic logic [4:0] regField(input logic [31:0] i, input int lsb);
      regField = i[lsb +: 5];
   endfunction

   // Byte count for a beat of the given size
   function automatic logic [31:0] sizeBytes(input logic [1:0] s);
      unique case (s)
         store_unit_pkg::SIZE_BYTE: sizeBytes = 32'h0000_0001;
         store_unit_pkg::SIZE_HALF: sizeBytes = 32'h0000_0002;
         default:                   sizeBytes = 32'h0000_0004;
      endcase
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   gpr_file u_gprs (
      .clk    (clk),
      .rstN   (rstN),
      .rdAddr (rdAddr),
      .rdData (rdData),
      .wrEn   (wrEn),
      .wrAddr (wrAddr),
      .wrData (wrData)
   );

   // Decoded instruction fields
   logic [1:0]  kind;
   logic [1:0]  size;
   logic        indexed;
   logic        update;
   logic        swap;
   logic [4:0]  baseField;
   logic [4:0]  countField;
   assign kind       = r.insn[store_unit_pkg::KIND_LSB +: 2];
   assign size       = r.insn[store_unit_pkg::SIZE_LSB +: 2];
   assign indexed    = r.insn[store_unit_pkg::INDEXED_BIT];
   assign update     = r.insn[store_unit_pkg::UPDATE_BIT];
   assign swap       = r.insn[store_unit_pkg::SWAP_BIT];
   assign baseField  = regField(r.insn, store_unit_pkg::BASE_LSB);
   assign countField = regField(r.insn, store_unit_pkg::INDEX_LSB);

   assign access = psel & penable;
   assign busy   = (r.st != IDLE);
   assign anyExc = storeExc.dataStorage | storeExc.translationMiss | storeExc.addrCompare;

   // Register file read address: the sequencer drives it in GET_BASE, GET_INDEX and GET_SRC, software's gprSel in every other state
   always_comb begin
      unique case (r.st)
         GET_BASE:  rdAddr = baseField;
         GET_INDEX: rdAddr = countField;
         GET_SRC:   rdAddr = r.srcReg;
         default:   rdAddr = r.gprSel;
      endcase
   end

   // Single write port: address write-back wins, software writes only while idle
   always_comb begin
      if (r.st == WRBACK) begin
         wrEn   = 1'b1;                    // RULE9
         wrAddr = baseField;
         wrData = r.ea;
      end else begin
         wrEn   = access & pwrite & !busy & (paddr == store_unit_pkg::GPR_DATA_OFFSET);
         wrAddr = r.gprSel;
         wrData = pwdata;
      end
   end

   // Storage request data, shaped by kind, size and swap
   always_comb begin
      storeReq.addr = r.cur;
      storeReq.data = r.word;
      storeReq.bytes = 3'h4;
      storeValid = (r.st == SEND);
      if (kind == store_unit_pkg::KIND_STRING_IMM || kind == store_unit_pkg::KIND_STRING_IDX) begin
         storeReq.bytes = 3'h1;
         storeReq.data = {24'h00_0000, r.word[(5'd31 - {r.byteIdx, 3'h0}) -: 8]}; // RULE16
      end else if (kind == store_unit_pkg::KIND_SINGLE) begin
         unique case (size)
            store_unit_pkg::SIZE_BYTE: begin
               storeReq.bytes = 3'h1;
               storeReq.data = {24'h00_0000, r.word[7:0]};                      // RULE4
            end
            store_unit_pkg::SIZE_HALF: begin
               storeReq.bytes = 3'h2;
               storeReq.data = {16'h0000, swap ? swapHalf(r.word[15:0])         // RULE6
                                               : r.word[15:0]};                 // RULE5
            end
            default: begin
               storeReq.data = swap ? swapWord(r.word) : r.word;                // RULE7 RULE8
            end
         endcase
      end
   end

   // Exception reported while a beat is on offer abandons the operation
   assign excTaken = (r.st == SEND) & anyExc;

   // APB answers in the access phase with no wait state
   always_comb begin
      pready  = 1'b1;
      pslverr = 1'b0;
      prdata  = 32'h0000_0000;
      if (access) begin
         unique case (paddr)
            store_unit_pkg::INSN_OFFSET:     begin
               prdata  = r.insn;
               pslverr = pwrite & busy;     // No launch while busy
            end
            store_unit_pkg::COUNT_OFFSET:    prdata = {25'h000_0000, r.count};
            store_unit_pkg::GPR_SEL_OFFSET:  prdata = {27'h000_0000, r.gprSel};
            store_unit_pkg::GPR_DATA_OFFSET: begin
               prdata  = busy ? 32'h0000_0000 : rdData;
               pslverr = busy;              // Read port belongs to the sequencer
            end
            store_unit_pkg::STATUS_OFFSET:   prdata = {29'h0000_0000, r.excSeen, r.invalid, busy};
            store_unit_pkg::LAST_EA_OFFSET:  prdata = r.ea;
            default:                         pslverr = 1'b1;
         endcase
      end
      if (pwrite) begin
         prdata = 32'h0;
      end
   end

   // Sequencer and software-visible state
   always_comb begin
      n = r;
      if (access & pwrite & !busy) begin
         if (paddr == store_unit_pkg::COUNT_OFFSET) begin
            n.count = pwdata[6:0];
         end
         if (paddr == store_unit_pkg::GPR_SEL_OFFSET) begin
            n.gprSel = pwdata[4:0];
         end
      end
      unique case (r.st)
         IDLE: begin
            if (access & pwrite & (paddr == store_unit_pkg::INSN_OFFSET)) begin
               n.insn    = pwdata;
               n.invalid = 1'b0;
               n.excSeen = 1'b0;
               // Record bit is accepted and ignored; condition field zero is not driven
               if (pwdata[store_unit_pkg::UPDATE_BIT] &&
                   regField(pwdata, store_unit_pkg::BASE_LSB) == store_unit_pkg::GPR_ZERO) begin
                  n.invalid = 1'b1;                                             // RULE9 RULE10
               end else if (pwdata[store_unit_pkg::KIND_LSB +: 2] == store_unit_pkg::KIND_STRING_IDX &&
                            r.count == 7'h00) begin
                  n.st = IDLE;                 // Nothing offered, so no exception can be taken; RULE18 RULE19
               end else begin
                  n.st = GET_BASE;
               end
            end
         end
         GET_BASE: begin
            n.st = GET_INDEX;
         end
         GET_INDEX: begin
            n.base = (baseField == store_unit_pkg::GPR_ZERO) ? 32'h0000_0000 : rdData; // RULE3
            n.st   = CALC;
         end
         CALC: begin
            if (kind == store_unit_pkg::KIND_STRING_IMM) begin
               n.ea = r.base;                                                   // RULE13
            end else if (indexed) begin
               n.ea = r.base + rdData;                                          // RULE1
            end else begin
               n.ea = r.base + {{16{r.insn[15]}}, r.insn[15:0]};                // RULE2
            end
            n.cur     = n.ea;
            n.srcReg  = regField(r.insn, store_unit_pkg::SOURCE_LSB);
            n.byteIdx = 2'h0;
            if (kind == store_unit_pkg::KIND_STRING_IMM) begin
               n.remain = (countField == 5'h00) ? store_unit_pkg::STRING_MAX_BYTES
                                                : {2'h0, countField};           // RULE14
            end else begin
               n.remain = r.count;                                              // RULE17
            end
            n.st = GET_SRC;
         end
         GET_SRC: begin
            n.st = LOAD;
         end
         LOAD: begin
            n.word = rdData;
            n.st   = SEND;
         end
         SEND: begin
            if (anyExc) begin
               n.excSeen = 1'b1;
               n.st      = IDLE;
            end else if (storeReady) begin
               unique case (kind)
                  store_unit_pkg::KIND_SINGLE: begin
                     n.st = update ? WRBACK : IDLE;
                  end
                  store_unit_pkg::KIND_MULTIPLE: begin
                     n.cur = r.cur + 32'h0000_0004;
                     if (r.srcReg == store_unit_pkg::GPR_LAST) begin
                        n.st = IDLE;
                     end else begin
                        n.srcReg = r.srcReg + 5'h01;                            // RULE11
                        n.st     = GET_SRC;
                     end
                  end
                  default: begin
                     n.cur    = r.cur + 32'h0000_0001;
                     n.remain = r.remain - 7'h01;
                     if (r.remain == 7'h01) begin
                        n.st = IDLE;                                            // RULE14 RULE17
                     end else if (r.byteIdx == store_unit_pkg::BYTE_LAST) begin
                        n.byteIdx = 2'h0;
                        n.srcReg  = r.srcReg + 5'h01;   // 31 wraps to 0; RULE15
                        n.st      = GET_SRC;
                     end else begin
                        n.byteIdx = r.byteIdx + 2'h1;
                     end
                  end
               endcase
            end
         end
         WRBACK: begin
            n.st = IDLE;
         end
      endcase
      // Interrupt drops the operation; relaunch starts again from the first register
      if (abortReq && busy) begin
         n.st = IDLE;                                                           // RULE12
      end
      n.cur = (n.st == CALC) ? r.cur : n.cur;
   end

   // State register
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         r <= '{st: IDLE, insn: store_unit_pkg::INSN_RESET, count: store_unit_pkg::COUNT_RESET,
                gprSel: 5'h00, base: 32'h0000_0000, ea: 32'h0000_0000, cur: 32'h0000_0000,
                word: 32'h0000_0000, srcReg: 5'h00, remain: 7'h00, byteIdx: 2'h0,
                invalid: 1'b0, excSeen: 1'b0};
      end else begin
         r <= n;
      end
   end

endmodule
`default_nettype wire

/* test/store_sink.sv */
// Storage path model that accepts store beats and logs them
`timescale 1ns/1ps
`default_nettype none
module store_sink (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rstN,
   // Beat from the unit
   input  wire logic                       storeValid,
   input  wire store_unit_pkg::store_req_s storeReq,
   output logic                            storeReady,
   output store_unit_pkg::store_exc_s      storeExc,
   // Bench controls: stall every other cycle, fault every beat
   input  wire logic                       stall,
   input  wire logic                       excOn
);
   logic        ph;
   int          n;
   logic [31:0] aLog [128];
   logic [31:0] dLog [128];
   logic [2:0]  bLog [128];

   // Slow mode halves the acceptance rate so held beats get exercised
   assign storeReady = stall ? ph : 1'b1;
   assign storeExc   = (excOn && storeValid) ? 3'h4 : 3'h0;

   // Log each beat that is taken without a fault
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ph <= 1'b0;
         n  <= 0;
      end else begin
         ph <= ~ph;
         if (storeValid && storeReady && !(|storeExc)) begin
            aLog[n] <= storeReq.addr;
            dLog[n] <= storeReq.data;
            bLog[n] <= storeReq.bytes;
            n       <= n + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* test/store_unit_chk.sv */
// Port-level checker for the store unit
`timescale 1ns/1ps
`default_nettype none
module store_unit_chk (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       rst_n,
   // APB
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [7:0]                 paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   // Storage path
   input wire logic                       storeValid,
   input wire store_unit_pkg::store_req_s storeReq,
   input wire logic                       storeReady,
   input wire store_unit_pkg::store_exc_s storeExc,
   input wire logic                       excTaken,
   input wire logic                       abortReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Steps of a transfer
   sequence s_taken;
      storeValid && storeReady && !excTaken;
   endsequence
   sequence s_held;
      storeValid && !storeReady && !excTaken && !abortReq;
   endsequence

   a_ready_now: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   a_bytes_legal: assert property (storeValid |-> storeReq.bytes inside {3'h1, 3'h2, 3'h4})
      else $error("bad beat size");
   a_hold_beat: assert property (s_held |=> storeValid && $stable(storeReq))
      else $error("beat changed before taken");
   a_exc_flag: assert property (storeValid |-> excTaken == (|storeExc))
      else $error("excTaken wrong");
   a_exc_stop: assert property (excTaken |=> !storeValid)
      else $error("beat after exception");
   a_word_gap: assert property (s_taken ##0 storeReq.bytes == 3'h4 |=> !storeValid [*2])
      else $error("next word too soon");
   a_byte_step: assert property (s_taken ##1 (storeValid && storeReq.bytes == 3'h1)
      |-> storeReq.addr == $past(storeReq.addr) + 32'h1)
      else $error("string address step wrong");
   a_abort_stop: assert property (abortReq |=> !storeValid)
      else $error("beat after abort");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
      else $error("unmapped access not refused");
   a_rd_zero: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("prdata outside read");
endmodule

bind store_unit store_unit_chk chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .storeValid(storeValid), .storeReq(storeReq), .storeReady(storeReady),
   .storeExc(storeExc), .excTaken(excTaken), .abortReq(abortReq)
);
`default_nettype wire

/* test/store_unit_bench.sv */
// Self-checking bench for the store unit
`timescale 1ns/1ps
`default_nettype none
module store_unit_bench;
   typedef struct packed {
      logic [31:0] insn;
      logic [2:0]  nb;
   } row_s;
   logic                       clk = 1'b0;
   logic                       rst_n = 1'b0;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic                       abortReq = 1'b0;
   logic                       stall = 1'b0;
   logic                       excOn = 1'b0;
   logic [7:0]                 paddr = 8'h00;
   logic [31:0]                pwdata = 32'h0;
   logic [31:0]                prdata;
   logic [31:0]                rd;
   logic [31:0]                i;
   logic                       pready;
   logic                       pslverr;
   logic                       er;
   logic                       storeValid;
   logic                       storeReady;
   logic                       excTaken;
   store_unit_pkg::store_req_s storeReq;
   store_unit_pkg::store_exc_s storeExc;
   int                         err_total = 0;
   int                         n_checks = 0;
   int                         cyc = 0;
   int                         k;
   int                         n0;
   row_s                       rows [7];

   // 40 MHz clock
   always #12.5 clk = ~clk;

   store_unit uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .storeValid(storeValid), .storeReq(storeReq), .storeReady(storeReady),
      .storeExc(storeExc), .excTaken(excTaken), .abortReq(abortReq));
   store_sink sink (.clk(clk), .rstN(rst_n), .storeValid(storeValid), .storeReq(storeReq),
      .storeReady(storeReady), .storeExc(storeExc), .stall(stall), .excOn(excOn));

   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // Register contents preset in every register, distinct per byte except in register 26
   function automatic logic [31:0] gv(input logic [4:0] n);
      gv = {3'h5, n, 8'h5a, 8'hc3, 3'h2, n};
   endfunction
   function automatic logic [31:0] mk(input logic [1:0] kd, s, input logic x, u,
      input logic [4:0] r, b, input logic [15:0] d);
      mk = {kd, s, x, u, r, b, d};
   endfunction
   function automatic logic [31:0] ea(input logic [31:0] n);
      ea = (n[20:16] == 5'h0 ? 32'h0 : gv(n[20:16])) + (n[27] ? gv(n[15:11]) : {{16{n[15]}}, n[15:0]});
   endfunction
   function automatic logic [31:0] dat(input logic [31:0] n);
      logic [31:0] v;
      v = gv(n[25:21]);
      case (n[29:28])
         2'h0: dat = {24'h0, v[7:0]};
         2'h1: dat = n[1] ? {16'h0, v[7:0], v[15:8]} : {16'h0, v[15:0]};
         default: dat = n[1] ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
      endcase
   endfunction

   // One APB transfer; result left in rd and er
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (!pready);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmp(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ckbeat(input int b, input logic [31:0] a, d, input logic [2:0] nb);
      cmp(sink.aLog[b], a);
      cmp(sink.dLog[b], d);
      cmp({29'h0, sink.bLog[b]}, {29'h0, nb});
   endtask
   // Launch and poll status until no longer busy
   task automatic run(input logic [31:0] n);
      n0 = sink.n;
      apb(1'b1, 8'h00, n);
      rd = 32'h1;
      while (rd[0]) apb(1'b0, 8'h10, 32'h0);
   endtask
   task automatic str(input logic [31:0] n, input logic [4:0] s, input logic [31:0] a, input int c);
      logic [31:0] v;
      run(n);
      cmp(32'(sink.n - n0), 32'(c));
      for (int j = 0; j < c; j++) begin
         v = gv(5'(s + j / 4));
         ckbeat(n0 + j, a + 32'(j), {24'h0, v[31 - 8 * (j % 4) -: 8]}, 3'h1);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      rows[0] = '{mk(2'h0, 2'h0, 1'b1, 1'b0, 5'd7, 5'd3, {5'd5, 11'h0}), 3'h1};
      rows[1] = '{mk(2'h0, 2'h0, 1'b0, 1'b0, 5'd2, 5'd0, 16'h0104), 3'h1};
      rows[2] = '{mk(2'h0, 2'h1, 1'b0, 1'b0, 5'd9, 5'd4, 16'hfff0), 3'h2};
      rows[3] = '{mk(2'h0, 2'h1, 1'b1, 1'b0, 5'd10, 5'd6, {5'd8, 11'h2}), 3'h2};
      rows[4] = '{mk(2'h0, 2'h2, 1'b0, 1'b0, 5'd12, 5'd11, 16'h7ffc), 3'h4};
      rows[5] = '{mk(2'h0, 2'h2, 1'b1, 1'b0, 5'd15, 5'd13, {5'd14, 11'h2}), 3'h4};
      rows[6] = '{mk(2'h0, 2'h2, 1'b1, 1'b0, 5'd16, 5'd0, {5'd1, 11'h1}), 3'h4};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h10, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, {25'h0, store_unit_pkg::COUNT_RESET});
      apb(1'b0, 8'h40, 32'h0);
      cmp({31'h0, er}, 32'h1);
      $display("test reset and registers done");
      for (k = 0; k < 32; k++) begin
         apb(1'b1, 8'h08, 32'(k));
         apb(1'b1, 8'h0c, gv(5'(k)));
      end
      // Single stores from the table
      for (k = 0; k < 7; k++) begin
         run(rows[k].insn);
         cmp(32'(sink.n - n0), 32'h1);
         ckbeat(n0, ea(rows[k].insn), dat(rows[k].insn), rows[k].nb);
      end
      $display("test single stores done");
      i = mk(2'h0, 2'h1, 1'b1, 1'b1, 5'd22, 5'd20, {5'd21, 11'h0});
      run(i);
      ckbeat(n0, ea(i), dat(i), 3'h2);
      apb(1'b1, 8'h08, 32'd20);
      apb(1'b0, 8'h0c, 32'h0);
      cmp(rd, gv(5'd20) + gv(5'd21));
      run(mk(2'h0, 2'h2, 1'b0, 1'b1, 5'd5, 5'd0, 16'h0010));
      cmp({31'(sink.n - n0), rd[1]}, 32'h1);
      $display("test update forms done");
      stall <= 1'b1;
      run(mk(2'h1, 2'h2, 1'b0, 1'b0, 5'd29, 5'd0, 16'h0100));
      cmp(32'(sink.n - n0), 32'h3);
      for (k = 0; k < 3; k++) ckbeat(n0 + k, 32'h100 + 32'(4 * k), gv(5'(29 + k)), 3'h4);
      str(mk(2'h2, 2'h0, 1'b0, 1'b0, 5'd30, 5'd5, 16'h0), 5'd30, gv(5'd5), 32);
      stall <= 1'b0;
      str(mk(2'h2, 2'h0, 1'b0, 1'b0, 5'd3, 5'd0, {5'd5, 11'h0}), 5'd3, 32'h0, 5);
      apb(1'b1, 8'h04, 32'h6);
      str(mk(2'h3, 2'h0, 1'b1, 1'b0, 5'd31, 5'd2, {5'd3, 11'h0}), 5'd31, gv(5'd2) + gv(5'd3), 6);
      $display("test multiple and string done");
      excOn <= 1'b1;
      run(mk(2'h0, 2'h2, 1'b0, 1'b0, 5'd12, 5'd11, 16'h0));
      cmp({31'(sink.n - n0), rd[2]}, 32'h1);
      apb(1'b1, 8'h04, 32'h0);
      run(mk(2'h3, 2'h0, 1'b1, 1'b0, 5'd31, 5'd2, {5'd3, 11'h0}));
      cmp({29'(sink.n - n0), rd[2:0]}, 32'h0);
      excOn <= 1'b0;
      $display("test faults and empty string done");
      // Abort after the first word, then the rerun starts over
      stall <= 1'b1;
      i = mk(2'h1, 2'h2, 1'b0, 1'b0, 5'd28, 5'd0, 16'h0200);
      n0 = sink.n;
      apb(1'b1, 8'h00, i);
      while (sink.n == n0) @(posedge clk);
      abortReq <= 1'b1;
      @(posedge clk);
      abortReq <= 1'b0;
      cmp(sink.aLog[n0], 32'h200);
      stall <= 1'b0;
      run(32'h0);
      run(i);
      cmp(32'(sink.n - n0), 32'h4);
      for (k = 0; k < 4; k++) ckbeat(n0 + k, 32'h200 + 32'(4 * k), gv(5'(28 + k)), 3'h4);
      $display("test abort restart done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
